// *** usb_charge_pkg.sv ***
// Constants and types for the charging-mode controller.
// Assumes a single 50 MHz clock domain.
package usb_charge_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  localparam int unsigned FS_RECOG_SEC     = 60;
  localparam longint unsigned FS_RECOG_CYC = longint'(FS_RECOG_SEC) * longint'(CLK_FREQ_HZ);
  localparam int unsigned DISCH_TIME_US    = 10;
  localparam int unsigned DISCH_CYC        = (DISCH_TIME_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned SYNC_STAGES      = 2;

  // ****************************************
  // Mode-select patterns {one,two,three}
  // ****************************************
  localparam logic [2:0] SEL_OFF       = 3'h0;
  localparam logic [2:0] SEL_AUTO_A    = 3'h1;
  localparam logic [2:0] SEL_STD1_A    = 3'h2;
  localparam logic [2:0] SEL_AUTO_B    = 3'h3;
  localparam logic [2:0] SEL_SHORTED   = 3'h4;
  localparam logic [2:0] SEL_DIVIDER   = 3'h5;
  localparam logic [2:0] SEL_STD1_B    = 3'h6;
  localparam logic [2:0] SEL_STD2_CDP  = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_DISCHARGE,
    MODE_AUTO_DEDICATED,
    MODE_STANDARD_FIRST,
    MODE_FORCED_SHORTED,
    MODE_FORCED_DIVIDER,
    MODE_STANDARD_SECOND,
    MODE_CHARGING_DOWNSTREAM
  } charge_mode_t;

  typedef enum logic [1:0] {
    LIM_NONE,
    LIM_LOW,
    LIM_HIGH
  } limit_t;

  typedef enum logic [1:0] {
    DC_IDLE,
    DC_DISCHARGE
  } disch_state_t;

endpackage : usb_charge_pkg

// *** usb_pin_sync.sv ***
// Two-flop synchroniser for a bus of level inputs.
// Assumes inputs are slow levels; no bus coherence.
`timescale 1ns/1ps
module usb_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r  <= '0;
      syncOut <= '0;
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule : usb_pin_sync

// *** usb_charge_mode_controller.sv ***
// Charging-mode decode, output discharge sequencing and HID wake hold.
// Assumes one 50 MHz clock; mode-select and limit pins may be asynchronous and are synchronised here.
`timescale 1ns/1ps

// Operation
// - During reset stay in initial state with output discharging.
// - Every reset returns logic to the initial state.
// - After reset release, enter the mode chosen by mode-select pins.
// - Discharge cycle: switch off, discharge output, then switch back on.
// - Data switches open throughout any output discharge.
// - All mode-select low: output held discharged, no current limit.
// - Patterns 0x1 select auto dedicated charging, high limit, data open.
// - Patterns 010 and 110 select first standard port, limit from select.
// - Pattern 100 forces shorted charging, limit from select.
// - Pattern 101 forces divider-one charging, limit from select.
// - Pattern 111 gives second standard (low) or downstream (high), data on.
// - Changing between 1111 and 1110 causes no discharge.
// - Follow commanded mode except while HID override applies.
// - With HID detected, hold data for 111->011 and 010->011.
// - Change 110->011 is never overridden.
// - Intermediate 111 from 110 enters 111 with its discharge.
// - Watch data lines only in standard or downstream modes.
// - Classify low or full speed while working, before override.
// - D+ falling after connect marks the device high speed.
// - Full speed needs 60 s connection to qualify; low speed immediate.
// - Data switches closed only in data modes with enable high.
// - Data open if enable low or pins low; not on current limit.
module usb_charge_mode_controller #(
  parameter longint unsigned FS_RECOG_CYCLES = usb_charge_pkg::FS_RECOG_CYC,
  parameter int unsigned     DISCH_CYCLES    = usb_charge_pkg::DISCH_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Control pins
  input  wire logic enable,
  input  wire logic mode_select_one,
  input  wire logic mode_select_two,
  input  wire logic mode_select_three,
  input  wire logic limit_select,
  // Data line levels
  input  wire logic dPlusHigh,
  input  wire logic dMinusHigh,
  // Power path
  output logic      powerSwitchOn,
  output logic      outDischarge,
  output logic      high_current_limit,
  output logic      low_current_limit,
  output logic      dataSwitchClosed,
  // Status
  output logic [2:0] chargeMode,
  output logic      hidDetected,
  output logic      wakeHold
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [3:0] pinsSync;
  logic [2:0] sel;
  logic       limSel;

  usb_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn ({mode_select_one, mode_select_two, mode_select_three, limit_select}),
    .syncOut (pinsSync)
  );

  assign sel    = pinsSync[3:1];
  assign limSel = pinsSync[0];

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic usb_charge_pkg::charge_mode_t decodeMode(input logic [2:0] s, input logic l);
    usb_charge_pkg::charge_mode_t m;
    m = usb_charge_pkg::MODE_DISCHARGE;
    case (s)
      usb_charge_pkg::SEL_OFF:      m = usb_charge_pkg::MODE_DISCHARGE;
      usb_charge_pkg::SEL_AUTO_A,
      usb_charge_pkg::SEL_AUTO_B:   m = usb_charge_pkg::MODE_AUTO_DEDICATED;
      usb_charge_pkg::SEL_STD1_A,
      usb_charge_pkg::SEL_STD1_B:   m = usb_charge_pkg::MODE_STANDARD_FIRST;
      usb_charge_pkg::SEL_SHORTED:  m = usb_charge_pkg::MODE_FORCED_SHORTED;
      usb_charge_pkg::SEL_DIVIDER:  m = usb_charge_pkg::MODE_FORCED_DIVIDER;
      usb_charge_pkg::SEL_STD2_CDP: m = l ? usb_charge_pkg::MODE_CHARGING_DOWNSTREAM
                                          : usb_charge_pkg::MODE_STANDARD_SECOND;
      default:                      m = usb_charge_pkg::MODE_DISCHARGE;
    endcase
    return m;
  endfunction : decodeMode

  function automatic logic isDataMode(input usb_charge_pkg::charge_mode_t m);
    return (m == usb_charge_pkg::MODE_STANDARD_FIRST) ||
           (m == usb_charge_pkg::MODE_STANDARD_SECOND) ||
           (m == usb_charge_pkg::MODE_CHARGING_DOWNSTREAM);
  endfunction : isDataMode

  usb_charge_pkg::charge_mode_t cmdMode;
  usb_charge_pkg::charge_mode_t mode_r;
  usb_charge_pkg::charge_mode_t mode_nxt;
  logic [2:0]                   prevSel_r;
  logic                         started_r;
  logic [1:0]                   warm_r;
  logic                         override_r;
  logic                         override_nxt;
  logic                         wakeQual;

  assign cmdMode = decodeMode(sel, limSel);

  // ****************************************
  // Wake override decision
  // ****************************************
  always_comb begin
    override_nxt = override_r;
    if (!started_r) begin
      override_nxt = 1'b0;
    end else if (override_r) begin
      // Held until the pins leave pattern 011, however long that takes
      if (sel != usb_charge_pkg::SEL_AUTO_B) begin
        override_nxt = 1'b0;
      end
    end else if (sel == usb_charge_pkg::SEL_AUTO_B && wakeQual &&
                 (prevSel_r == usb_charge_pkg::SEL_STD2_CDP ||
                  prevSel_r == usb_charge_pkg::SEL_STD1_A)) begin
      override_nxt = 1'b1;
    end
  end

  // ****************************************
  // Mode state
  // ****************************************
  always_comb begin
    mode_nxt = mode_r;
    if (!started_r) begin
      // Wait for valid synchronised pins
      mode_nxt = warm_r[1] ? cmdMode : mode_r;
    end else if (override_nxt) begin
      mode_nxt = mode_r;
    end else begin
      mode_nxt = cmdMode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r     <= usb_charge_pkg::MODE_INIT;
      started_r  <= 1'b0;
      warm_r     <= 2'h0;
      override_r <= 1'b0;
      prevSel_r  <= usb_charge_pkg::SEL_OFF;
    end else begin
      mode_r     <= mode_nxt;
      started_r  <= warm_r[1];
      warm_r     <= {warm_r[0], 1'b1};
      override_r <= override_nxt;
      prevSel_r  <= sel;
    end
  end

  // ****************************************
  // Discharge sequencing
  // ****************************************
  usb_charge_pkg::disch_state_t dcState_r;
  logic [31:0]                  dcCount_r;
  logic                         modeChange;
  logic                         quietChange;

  assign modeChange  = (mode_nxt != mode_r) && started_r;
  assign quietChange = ((mode_r == usb_charge_pkg::MODE_STANDARD_SECOND) &&
                        (mode_nxt == usb_charge_pkg::MODE_CHARGING_DOWNSTREAM)) ||
                       ((mode_r == usb_charge_pkg::MODE_CHARGING_DOWNSTREAM) &&
                        (mode_nxt == usb_charge_pkg::MODE_STANDARD_SECOND));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcState_r <= usb_charge_pkg::DC_IDLE;
      dcCount_r <= '0;
    end else begin
      case (dcState_r)
        usb_charge_pkg::DC_IDLE: begin
          if (modeChange && !quietChange) begin
            dcState_r <= usb_charge_pkg::DC_DISCHARGE;
            dcCount_r <= '0;
          end
        end
        usb_charge_pkg::DC_DISCHARGE: begin
          if (modeChange && !quietChange) begin
            dcCount_r <= '0;
          end else if (dcCount_r >= DISCH_CYCLES - 1) begin
            dcState_r <= usb_charge_pkg::DC_IDLE;
          end else begin
            dcCount_r <= dcCount_r + 32'h0000_0001;
          end
        end
        default: dcState_r <= usb_charge_pkg::DC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Data line monitor
  // ****************************************
  logic        lsSeen_r;
  logic        fsSeen_r;
  logic        hsSeen_r;
  logic [63:0] fsTime_r;
  logic        fsQual_r;
  logic        monitoring;

  assign monitoring = isDataMode(mode_r) && !override_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsSeen_r <= 1'b0;
      fsSeen_r <= 1'b0;
      hsSeen_r <= 1'b0;
      fsTime_r <= '0;
      fsQual_r <= 1'b0;
    end else if (monitoring) begin
      if (!dPlusHigh && !dMinusHigh && !fsSeen_r) begin
        lsSeen_r <= 1'b0;
        fsTime_r <= '0;
        fsQual_r <= 1'b0;
      end else if (dMinusHigh && !dPlusHigh) begin
        lsSeen_r <= 1'b1;
      end
      if (dPlusHigh && !dMinusHigh && !fsSeen_r) begin
        fsSeen_r <= 1'b1;
        hsSeen_r <= 1'b0;
        fsTime_r <= '0;
      end else if (fsSeen_r && !dPlusHigh) begin
        hsSeen_r <= 1'b1;
        fsSeen_r <= 1'b0;
        fsQual_r <= 1'b0;
      end else if (fsSeen_r && !hsSeen_r) begin
        if (fsTime_r >= FS_RECOG_CYCLES - 1) begin
          fsQual_r <= 1'b1;
        end else begin
          fsTime_r <= fsTime_r + 64'h0000_0000_0000_0001;
        end
      end
    end else if (!isDataMode(mode_r) && !override_r) begin
      lsSeen_r <= 1'b0;
      fsSeen_r <= 1'b0;
      hsSeen_r <= 1'b0;
      fsTime_r <= '0;
      fsQual_r <= 1'b0;
    end
  end

  assign wakeQual = lsSeen_r || fsQual_r;

  // ****************************************
  // Outputs
  // ****************************************
  logic discharging;
  assign discharging = (mode_r == usb_charge_pkg::MODE_INIT) ||
                       (mode_r == usb_charge_pkg::MODE_DISCHARGE) ||
                       (dcState_r == usb_charge_pkg::DC_DISCHARGE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerSwitchOn      <= 1'b0;
      outDischarge       <= 1'b1;
      high_current_limit <= 1'b0;
      low_current_limit  <= 1'b0;
      dataSwitchClosed   <= 1'b0;
      chargeMode         <= 3'h0;
      hidDetected        <= 1'b0;
      wakeHold           <= 1'b0;
    end else begin
      powerSwitchOn      <= !discharging;
      outDischarge       <= discharging;
      high_current_limit <= (mode_r == usb_charge_pkg::MODE_AUTO_DEDICATED) ||
                            (mode_r == usb_charge_pkg::MODE_CHARGING_DOWNSTREAM) ||
                            ((mode_r == usb_charge_pkg::MODE_STANDARD_FIRST ||
                              mode_r == usb_charge_pkg::MODE_FORCED_SHORTED ||
                              mode_r == usb_charge_pkg::MODE_FORCED_DIVIDER) && limSel);
      low_current_limit  <= (mode_r == usb_charge_pkg::MODE_STANDARD_SECOND) ||
                            ((mode_r == usb_charge_pkg::MODE_STANDARD_FIRST ||
                              mode_r == usb_charge_pkg::MODE_FORCED_SHORTED ||
                              mode_r == usb_charge_pkg::MODE_FORCED_DIVIDER) && !limSel);
      dataSwitchClosed   <= isDataMode(mode_r) && enable && (sel != usb_charge_pkg::SEL_OFF) &&
                            (dcState_r != usb_charge_pkg::DC_DISCHARGE);
      chargeMode         <= 3'(mode_r);
      hidDetected        <= wakeQual;
      wakeHold           <= override_r;
    end
  end

endmodule : usb_charge_mode_controller

// *** usb_charge_properties.sv ***
// Concurrent checks on the charging-mode controller ports.
// Assumes it is bound onto the controller; one clock domain.
`timescale 1ns/1ps
module usb_charge_properties #(
  parameter int unsigned DISCH_CYCLES = 4
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Watched ports
  input wire logic       enable,
  input wire logic       powerSwitchOn,
  input wire logic       outDischarge,
  input wire logic       high_current_limit,
  input wire logic       low_current_limit,
  input wire logic       dataSwitchClosed,
  input wire logic [2:0] chargeMode,
  input wire logic       hidDetected,
  input wire logic       wakeHold
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int unsigned run_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) run_r <= '0;
    else run_r <= (outDischarge && chargeMode > 3'h1) ? run_r + 1'h1 : '0;
  end
  a_reset_state: assert property (disable iff (1'h0) !rst_n |-> outDischarge && !powerSwitchOn
    && chargeMode == usb_charge_pkg::MODE_INIT) else $error("reset state wrong");
  a_disch_power_off: assert property (outDischarge |-> !powerSwitchOn) else $error("power on in discharge");
  a_disch_data_open: assert property (outDischarge |-> !dataSwitchClosed) else $error("data closed in discharge");
  a_disch_length: assert property ($fell(outDischarge) && $past(chargeMode) != 3'h0 |-> powerSwitchOn
    && run_r >= DISCH_CYCLES && run_r <= DISCH_CYCLES + 1) else $error("discharge length wrong");
  a_off_no_limit: assert property (chargeMode == usb_charge_pkg::MODE_DISCHARGE |-> outDischarge
    && !high_current_limit && !low_current_limit) else $error("off mode wrong");
  a_auto_high_open: assert property (chargeMode == usb_charge_pkg::MODE_AUTO_DEDICATED |-> high_current_limit
    && !low_current_limit && !dataSwitchClosed) else $error("auto mode wrong");
  a_limit_one_hot: assert property (!(high_current_limit && low_current_limit)) else $error("both limits");
  a_data_mode_only: assert property (dataSwitchClosed |-> chargeMode inside {3'h3, 3'h6, 3'h7})
    else $error("data closed in charging mode");
  a_enable_opens: assert property (!enable [*4] |-> !dataSwitchClosed) else $error("data closed, enable low");
  a_cdp_no_disch: assert property (chargeMode != $past(chargeMode) && chargeMode inside {3'h6, 3'h7}
    && $past(chargeMode) inside {3'h6, 3'h7} |-> !outDischarge) else $error("discharge on 1110 1111");
  a_hold_needs_hid: assert property (wakeHold |-> hidDetected
    && chargeMode != usb_charge_pkg::MODE_AUTO_DEDICATED) else $error("hold without device");
  c_hold: cover property ($rose(wakeHold));
  c_hid: cover property ($rose(hidDetected));
  c_disch: cover property ($rose(outDischarge));
endmodule : usb_charge_properties

// *** usb_dev_model.sv ***
// Idle line levels of an attached low, full or high speed device.
// Assumes host pull-downs: detached lines read low.
`timescale 1ns/1ps
module usb_dev_model (
  // Clock
  input  wire logic       ref_clk,
  // Kind: 0 none, 1 low, 2 full, 3 high speed
  input  wire logic [1:0] kind,
  // Line levels
  output logic            dPlus,
  output logic            dMinus
);
  logic [3:0] age_r;
  always_ff @(posedge ref_clk) begin
    age_r <= (kind == 2'h3) ? age_r + (age_r != 4'hf) : 4'h0;
  end
  always_comb begin
    dMinus = (kind == 2'h1);
    dPlus  = (kind == 2'h2) || (kind == 2'h3 && age_r < 4'h8);
  end
endmodule : usb_dev_model

// *** tb_top.sv ***
// Self-checking bench for the charging-mode controller.
// Assumes short sim counts: recognition 50, discharge 4 cycles.
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk, rst_n, enable, limSel, dPlus, dMinus;
  logic [2:0] pins, chargeMode;
  logic [1:0] kind;
  logic       powerSwitchOn, outDischarge, hiLim, loLim, dataSwitchClosed, hidDetected, wakeHold;
  int         bad_count, checks;
  usb_charge_mode_controller #(.FS_RECOG_CYCLES(50), .DISCH_CYCLES(4)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .enable(enable), .mode_select_one(pins[2]),
    .mode_select_two(pins[1]), .mode_select_three(pins[0]), .limit_select(limSel),
    .dPlusHigh(dPlus), .dMinusHigh(dMinus), .powerSwitchOn(powerSwitchOn), .outDischarge(outDischarge),
    .high_current_limit(hiLim), .low_current_limit(loLim), .dataSwitchClosed(dataSwitchClosed),
    .chargeMode(chargeMode), .hidDetected(hidDetected), .wakeHold(wakeHold));
  usb_dev_model dev (.ref_clk(ref_clk), .kind(kind), .dPlus(dPlus), .dMinus(dMinus));
  // ****************************************
  // Helpers
  // ****************************************
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  function automatic logic [7:0] outs();
    return {chargeMode, hiLim, loLim, dataSwitchClosed, outDischarge, powerSwitchOn};
  endfunction : outs
  function automatic logic [7:0] expOf(input logic [2:0] p, input logic l);
    logic [2:0] m;
    logic       d;
    d = 1'h0;
    case (p)
      3'h0: return {usb_charge_pkg::MODE_DISCHARGE, 5'h02};
      3'h2, 3'h6: begin m = usb_charge_pkg::MODE_STANDARD_FIRST; d = 1'h1; end
      3'h4: m = usb_charge_pkg::MODE_FORCED_SHORTED;
      3'h5: m = usb_charge_pkg::MODE_FORCED_DIVIDER;
      3'h7: begin m = l ? usb_charge_pkg::MODE_CHARGING_DOWNSTREAM : usb_charge_pkg::MODE_STANDARD_SECOND; d = 1'h1; end
      default: return {usb_charge_pkg::MODE_AUTO_DEDICATED, 5'h11};
    endcase
    return {m, l, !l, d, 2'h1};
  endfunction : expOf
  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    cyc(12);
    chk(outs(), {usb_charge_pkg::MODE_INIT, 5'h02});
    rst_n = 1'h1; cyc(10);
    chk(outs(), expOf(3'h6, 1'h1));
    rst_n = 1'h0; cyc(1);
    chk(outs(), {usb_charge_pkg::MODE_INIT, 5'h02});
    rst_n = 1'h1; cyc(10);
    chk(outs(), expOf(3'h6, 1'h1));
    $display("t_reset done");
  endtask : t_reset
  task automatic t_table();
    for (int i = 0; i < 16; i++) begin
      pins = i[3:1]; limSel = i[0]; cyc(20);
      chk(outs(), expOf(i[3:1], i[0]));
    end
    $display("t_table done");
  endtask : t_table
  task automatic t_disch();
    pins = 3'h6; limSel = 1'h1; cyc(20);
    pins = 3'h4; cyc(5);
    chk(outs(), {usb_charge_pkg::MODE_FORCED_SHORTED, 5'h12});
    cyc(10);
    chk(outs(), expOf(3'h4, 1'h1));
    $display("t_disch done");
  endtask : t_disch
  task automatic t_cdp();
    pins = 3'h7; limSel = 1'h0; cyc(20);
    for (int i = 0; i < 4; i++) begin
      limSel = ~limSel;
      repeat (8) begin cyc(1); chk(outDischarge, 8'h00); end
    end
    chk(outs(), expOf(3'h7, 1'h0));
    $display("t_cdp done");
  endtask : t_cdp
  task automatic t_enable();
    pins = 3'h6; cyc(20);
    enable = 1'h0; cyc(6);
    chk(dataSwitchClosed, 8'h00);
    enable = 1'h1; cyc(6);
    chk(dataSwitchClosed, 8'h01);
    $display("t_enable done");
  endtask : t_enable
  task automatic t_low_speed();
    pins = 3'h7; limSel = 1'h0; cyc(20);
    kind = 2'h1; cyc(10);
    chk(hidDetected, 8'h01);
    pins = 3'h3; limSel = 1'h1; cyc(20);
    chk(outs(), expOf(3'h7, 1'h0));
    chk(wakeHold, 8'h01);
    cyc(300); pins = 3'h7; limSel = 1'h0; cyc(10);
    chk(wakeHold, 8'h00);
    pins = 3'h6; cyc(20); pins = 3'h7; cyc(5);
    chk(outDischarge, 8'h01);
    cyc(15); pins = 3'h6; cyc(20); pins = 3'h3; cyc(20);
    chk(outs(), expOf(3'h3, 1'h0));
    chk(wakeHold, 8'h00);
    kind = 2'h0;
    $display("t_low_speed done");
  endtask : t_low_speed
  task automatic t_full_speed();
    pins = 3'h2; limSel = 1'h1; cyc(20);
    kind = 2'h2; cyc(30);
    chk(hidDetected, 8'h00);
    cyc(40);
    chk(hidDetected, 8'h01);
    pins = 3'h3; cyc(20);
    chk(outs(), expOf(3'h2, 1'h1));
    kind = 2'h0; pins = 3'h1; cyc(20);
    $display("t_full_speed done");
  endtask : t_full_speed
  task automatic t_high_speed();
    pins = 3'h2; cyc(20);
    kind = 2'h3; cyc(80);
    chk(hidDetected, 8'h00);
    pins = 3'h3; cyc(20);
    chk(outs(), expOf(3'h3, 1'h1));
    kind = 2'h0;
    $display("t_high_speed done");
  endtask : t_high_speed
  initial begin
    ref_clk = 1'h0; rst_n = 1'h1; enable = 1'h1; pins = 3'h6; limSel = 1'h1; kind = 2'h0;
    bad_count = 0; checks = 0;
    #1;
    rst_n = 1'h0;
    t_reset(); t_table(); t_disch(); t_cdp(); t_enable();
    t_low_speed(); t_full_speed(); t_high_speed();
    end_of_test();
  end
  initial begin
    #200us;
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
bind usb_charge_mode_controller usb_charge_properties #(.DISCH_CYCLES(DISCH_CYCLES)) props (
  .ref_clk, .rst_n, .enable, .powerSwitchOn, .outDischarge, .high_current_limit, .low_current_limit,
  .dataSwitchClosed, .chargeMode, .hidDetected, .wakeHold);
